// ### logic/sfb_regs.vh
// register map, reset values and timing counts of the fieldbus slave configuration block
`ifndef SFB_REGS_VH
`define SFB_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SFB_A_RATE      8'h00
`define SFB_A_ADDR      8'h04
`define SFB_A_PZD       8'h08
`define SFB_A_PKW       8'h0c
`define SFB_A_PROC      8'h10
`define SFB_A_GAP       8'h14
`define SFB_A_DEAD      8'h18
`define SFB_A_PROT      8'h1c
`define SFB_A_PAR       8'h20
`define SFB_A_MON       8'h24
`define SFB_A_STAT      8'h28
`define SFB_A_IRQ       8'h2c
`define SFB_A_MASK      8'h30
`define SFB_A_CNT0      8'h40
`define SFB_A_CNT7      8'h5c
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SFB_RATE_RST    4'h8
`define SFB_RATE_MIN    4'h4
`define SFB_RATE_MAX    4'hd
`define SFB_ADDR_MAX    5'h1e
`define SFB_PZD_RST     8'h02
`define SFB_PKW_VAR     7'h7f
`define SFB_PROC_RST    16'h03e8
`define SFB_MON_RST     16'h0064
`define SFB_PROT_SERIAL 2'h1
`define SFB_PAR_NONE    2'h0
`define SFB_PAR_EVEN    2'h2
// ----------------------------------------
// status and interrupt fields
// ----------------------------------------
`define SFB_IRQ_LINK    0
`define SFB_IRQ_PROC    1
`define SFB_IRQ_GAP     2
`define SFB_IRQ_REJ     3
`define SFB_IRQ_W       4
// ----------------------------------------
// timing
// ----------------------------------------
`define SFB_CLK_HZ      125000000
`define SFB_CLK_NS      8
`define SFB_MS_NS       1000000
`define SFB_MS_CYCLES   (`SFB_MS_NS / `SFB_CLK_NS)
`define SFB_GAP_INH_MS  16'h0002
`endif

// ### logic/sfb_slave_cfg.v
// fieldbus serial slave configuration, timing supervision and error statistics
`timescale 1ns/10ps
// Operation
// - bit rate code 4..13, default 8
// - software address accepted 0..30, default 0
// - switch zero selects software address
// - address latched only after reset
// - process word count, default two
// - parameter words 0, 3, 4, 127 variable
// - processing time limit, default 1000 ms
// - character gap limit, zero means inherent
// - dead time between telegrams, default zero
// - counters: good and rejected telegrams
// - counters: framing and overrun errors
// - counters: parity and start-character errors
// - counters: checksum and length errors
// - protocol runs when selection equals one
// - parity none, odd, even; default even
// - link monitor time, default 100 ms
// - monitor time zero disables monitoring
`include "sfb_regs.vh"
module sfb_slave_cfg #(
  parameter SW_W      = 7,
  parameter MS_CYCLES = `SFB_MS_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [SW_W-1:0] addr_switch,
  input  wire [7:0]  stat_event,
  input  wire        rx_char,
  input  wire        reply_done,
  output reg  [15:0] baud_divisor,
  output reg  [4:0]  active_address,
  output reg         address_valid,
  output reg  [7:0]  process_data_words,
  output reg  [6:0]  parameter_channel_words,
  output reg         protocol_enable,
  output reg  [1:0]  parity_mode,
  output reg         telegram_accept,
  output reg         gap_timeout,
  output reg         tx_inhibit,
  output reg         link_fault,
  output wire        irq
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function [15:0] rate_div;
    input [3:0] code;
    reg   [31:0] q;
    begin
      case (code)
        4'h4: q = `SFB_CLK_HZ / 2400;
        4'h5: q = `SFB_CLK_HZ / 4800;
        4'h6: q = `SFB_CLK_HZ / 9600;
        4'h7: q = `SFB_CLK_HZ / 19200;
        4'h8: q = `SFB_CLK_HZ / 38400;
        4'h9: q = `SFB_CLK_HZ / 57600;
        4'ha: q = `SFB_CLK_HZ / 76800;
        4'hb: q = `SFB_CLK_HZ / 93750;
        4'hc: q = `SFB_CLK_HZ / 115200;
        default: q = `SFB_CLK_HZ / 187500;
      endcase
      // slowest rate still fits sixteen bits
      rate_div = q[15:0];
    end
  endfunction

  function pkw_ok;
    input [31:0] v;
    begin
      pkw_ok = (v == 32'h0) || (v == 32'h3) || (v == 32'h4) || (v == 32'h7f);
    end
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  reg  [7:0]  aw_addr;
  reg         aw_full;
  reg  [31:0] w_data;
  reg         w_full;
  reg  [3:0]  wr_strb;
  reg  [3:0]  rate_code;
  reg  [4:0]  addr_setting;
  reg  [15:0] proc_ms;
  reg  [15:0] gap_ms;
  reg  [15:0] dead_ms;
  reg  [1:0]  prot_sel;
  reg  [15:0] mon_ms;
  reg  [`SFB_IRQ_W-1:0] irq_stat;
  reg  [`SFB_IRQ_W-1:0] irq_mask;
  reg  [31:0] err_cnt [0:7];
  reg  [31:0] rd_mux;
  reg         rd_hit;
  wire        do_wr;
  wire        wr_full_word;
  reg  [`SFB_IRQ_W-1:0] irq_evt;

  assign s_axi_awready = ~aw_full;
  assign s_axi_wready  = ~w_full;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr         = aw_full & w_full & ~s_axi_bvalid;
  // every setting only changes on a whole-word write; an interrupt clear does not need one
  assign wr_full_word  = &wr_strb;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      wr_strb       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full        <= 1'b1;
        w_data        <= s_axi_wdata;
        wr_strb       <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= `SFB_A_MASK || (aw_addr >= `SFB_A_CNT0 &&
                         aw_addr <= `SFB_A_CNT7)) && aw_addr[1:0] == 2'h0 ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // settings written by software; out-of-range rate, address, word-count and parity values are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      rate_code               <= `SFB_RATE_RST;
      addr_setting            <= 5'h00;
      process_data_words      <= `SFB_PZD_RST;
      parameter_channel_words <= `SFB_PKW_VAR;
      proc_ms                 <= `SFB_PROC_RST;
      gap_ms                  <= 16'h0000;
      dead_ms                 <= 16'h0000;
      prot_sel                <= `SFB_PROT_SERIAL;
      parity_mode             <= `SFB_PAR_EVEN;
      mon_ms                  <= `SFB_MON_RST;
      irq_mask                <= {`SFB_IRQ_W{1'b0}};
    end else if (do_wr && wr_full_word) begin
      case (aw_addr)
        `SFB_A_RATE: begin
          if (w_data >= {28'h0, `SFB_RATE_MIN} && w_data <= {28'h0, `SFB_RATE_MAX})
            rate_code <= w_data[3:0];
        end
        `SFB_A_ADDR: begin
          if (w_data <= {27'h0, `SFB_ADDR_MAX})
            addr_setting <= w_data[4:0];
        end
        `SFB_A_PZD: begin
          if (w_data[31:8] == 24'h0)
            process_data_words <= w_data[7:0];
        end
        `SFB_A_PKW: begin
          if (pkw_ok(w_data))
            parameter_channel_words <= w_data[6:0];
        end
        `SFB_A_PROC: proc_ms <= w_data[15:0];
        `SFB_A_GAP:  gap_ms <= w_data[15:0];
        `SFB_A_DEAD: dead_ms <= w_data[15:0];
        `SFB_A_PROT: prot_sel <= w_data[1:0];
        `SFB_A_PAR: begin
          if (w_data <= {30'h0, `SFB_PAR_EVEN})
            parity_mode <= w_data[1:0];
        end
        `SFB_A_MON:  mon_ms <= w_data[15:0];
        `SFB_A_MASK: irq_mask <= w_data[`SFB_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0;
    case (s_axi_araddr)
      `SFB_A_RATE: rd_mux = {28'h0, rate_code};
      `SFB_A_ADDR: rd_mux = {27'h0, addr_setting};
      `SFB_A_PZD:  rd_mux = {24'h0, process_data_words};
      `SFB_A_PKW:  rd_mux = {25'h0, parameter_channel_words};
      `SFB_A_PROC: rd_mux = {16'h0, proc_ms};
      `SFB_A_GAP:  rd_mux = {16'h0, gap_ms};
      `SFB_A_DEAD: rd_mux = {16'h0, dead_ms};
      `SFB_A_PROT: rd_mux = {30'h0, prot_sel};
      `SFB_A_PAR:  rd_mux = {30'h0, parity_mode};
      `SFB_A_MON:  rd_mux = {16'h0, mon_ms};
      `SFB_A_STAT: rd_mux = {24'h0, tx_inhibit, link_fault, address_valid, active_address};
      `SFB_A_IRQ:  rd_mux = {{(32-`SFB_IRQ_W){1'b0}}, irq_stat};
      `SFB_A_MASK: rd_mux = {{(32-`SFB_IRQ_W){1'b0}}, irq_mask};
      default: begin
        if (s_axi_araddr >= `SFB_A_CNT0 && s_axi_araddr <= `SFB_A_CNT7 &&
            s_axi_araddr[1:0] == 2'h0)
          rd_mux = err_cnt[s_axi_araddr[4:2]];
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // slave address capture
  // ----------------------------------------
  reg  [SW_W-1:0] sw_s1;
  reg  [SW_W-1:0] sw_s2;
  reg  [SW_W-1:0] sw_s3;
  reg  [1:0]      settle;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sw_s1          <= {SW_W{1'b0}};
      sw_s2          <= {SW_W{1'b0}};
      sw_s3          <= {SW_W{1'b0}};
      settle         <= 2'h0;
      address_valid  <= 1'b0;
      active_address <= 5'h00;
    end else begin
      sw_s1 <= addr_switch;
      sw_s2 <= sw_s1;
      sw_s3 <= sw_s2;
      if (settle != 2'h3)
        settle <= settle + 2'h1;
      // taken once after reset; later writes wait for the next reset
      if (!address_valid && settle == 2'h3 && sw_s2 == sw_s3) begin
        address_valid  <= 1'b1;
        active_address <= (sw_s3 == {SW_W{1'b0}}) ? addr_setting : sw_s3[4:0];
      end
    end
  end

  // ----------------------------------------
  // telegram qualification and statistics
  // ----------------------------------------
  wire any_err = |stat_event[7:2];
  wire tel_end = |stat_event;
  genvar gi;

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cnt
      always @(posedge aclk) begin
        if (!aresetn)
          err_cnt[gi] <= 32'h0;
        else if (stat_event[gi])
          err_cnt[gi] <= err_cnt[gi] + 32'h1;
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_divisor    <= rate_div(`SFB_RATE_RST);
      protocol_enable <= 1'b0;
      telegram_accept <= 1'b0;
    end else begin
      baud_divisor    <= rate_div(rate_code);
      protocol_enable <= (prot_sel == `SFB_PROT_SERIAL) && address_valid;
      // a good telegram with any error flag in the same cycle is dropped
      telegram_accept <= stat_event[0] & ~stat_event[1] & ~any_err & protocol_enable;
    end
  end

  // ----------------------------------------
  // millisecond timers
  // ----------------------------------------
  reg  [16:0] tick_cnt;
  reg         ms_tick;
  reg  [15:0] mon_cnt;
  reg  [15:0] proc_cnt;
  reg         proc_run;
  reg  [15:0] gap_cnt;
  reg         in_tel;
  reg  [15:0] dead_cnt;
  wire [15:0] gap_lim = (gap_ms == 16'h0) ? `SFB_GAP_INH_MS : gap_ms;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 17'h0;
      ms_tick  <= 1'b0;
    end else begin
      ms_tick  <= (tick_cnt == MS_CYCLES - 1);
      tick_cnt <= (tick_cnt == MS_CYCLES - 1) ? 17'h0 : tick_cnt + 17'h1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mon_cnt     <= 16'h0;
      link_fault  <= 1'b0;
      proc_cnt    <= 16'h0;
      proc_run    <= 1'b0;
      gap_cnt     <= 16'h0;
      in_tel      <= 1'b0;
      gap_timeout <= 1'b0;
      dead_cnt    <= 16'h0;
      tx_inhibit  <= 1'b0;
      irq_evt     <= {`SFB_IRQ_W{1'b0}};
    end else begin
      irq_evt <= {`SFB_IRQ_W{1'b0}};
      // link supervision
      if (mon_ms == 16'h0 || !protocol_enable || telegram_accept) begin
        mon_cnt    <= 16'h0;
        link_fault <= 1'b0;
      end else if (ms_tick && !link_fault) begin
        mon_cnt <= mon_cnt + 16'h1;
        if (mon_cnt + 16'h1 >= mon_ms) begin
          link_fault                 <= 1'b1;
          irq_evt[`SFB_IRQ_LINK]     <= 1'b1;
        end
      end
      // processing time from accept to reply
      if (telegram_accept) begin
        proc_run <= 1'b1;
        proc_cnt <= 16'h0;
      end else if (reply_done) begin
        proc_run <= 1'b0;
      end else if (proc_run && ms_tick) begin
        proc_cnt <= proc_cnt + 16'h1;
        if (proc_cnt + 16'h1 >= proc_ms) begin
          proc_run               <= 1'b0;
          irq_evt[`SFB_IRQ_PROC] <= 1'b1;
        end
      end
      // character gap inside a telegram
      gap_timeout <= 1'b0;
      if (tel_end) begin
        in_tel  <= 1'b0;
        gap_cnt <= 16'h0;
      end else if (rx_char) begin
        in_tel  <= 1'b1;
        gap_cnt <= 16'h0;
      end else if (in_tel && ms_tick) begin
        gap_cnt <= gap_cnt + 16'h1;
        if (gap_cnt + 16'h1 >= gap_lim) begin
          in_tel                <= 1'b0;
          gap_timeout           <= 1'b1;
          irq_evt[`SFB_IRQ_GAP] <= 1'b1;
        end
      end
      // line quiet time after each telegram end
      if (tel_end && dead_ms != 16'h0) begin
        tx_inhibit <= 1'b1;
        dead_cnt   <= 16'h0;
      end else if (tx_inhibit && ms_tick) begin
        dead_cnt <= dead_cnt + 16'h1;
        if (dead_cnt + 16'h1 >= dead_ms)
          tx_inhibit <= 1'b0;
      end
      if (stat_event[1])
        irq_evt[`SFB_IRQ_REJ] <= 1'b1;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire wr_irq = do_wr && aw_addr == `SFB_A_IRQ;

  always @(posedge aclk) begin
    if (!aresetn)
      irq_stat <= {`SFB_IRQ_W{1'b0}};
    else // set wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~(wr_irq ? w_data[`SFB_IRQ_W-1:0] : {`SFB_IRQ_W{1'b0}}))
                  | irq_evt;
  end

  assign irq = |(irq_stat & irq_mask);

endmodule

// ### tb/sfb_rx_model.sv
// receive engine stand-in that feeds telegram events into the block
`timescale 1ns/10ps
module sfb_rx_model (
  input  wire       aclk,
  input  wire       tx_inhibit,
  output reg  [7:0] stat_event,
  output reg        rx_char,
  output reg        reply_done
);
  initial begin
    stat_event = 8'h00;
    rx_char    = 1'b0;
    reply_done = 1'b0;
  end
  // one character, verdict on the next cycle; an empty verdict leaves the telegram open
  task send(input [7:0] ev);
    begin
      @(posedge aclk);
      #1;
      // the master keeps quiet until the dead time is over
      while (tx_inhibit) begin
        @(posedge aclk);
        #1;
      end
      @(posedge aclk);
      rx_char <= 1'b1;
      @(posedge aclk);
      rx_char    <= 1'b0;
      stat_event <= ev;
      @(posedge aclk);
      stat_event <= 8'h00;
    end
  endtask
  task reply;
    begin
      @(posedge aclk);
      reply_done <= 1'b1;
      @(posedge aclk);
      reply_done <= 1'b0;
    end
  endtask
endmodule

// ### tb/sfb_slave_cfg_properties.sv
// port assertions for the fieldbus slave configuration block
`timescale 1ns/10ps
module sfb_slave_cfg_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  stat_event,
  input wire [15:0] baud_divisor,
  input wire [4:0]  active_address,
  input wire        address_valid,
  input wire [7:0]  process_data_words,
  input wire [6:0]  parameter_channel_words,
  input wire        protocol_enable,
  input wire [1:0]  parity_mode,
  input wire        telegram_accept,
  input wire        link_fault
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------
  // telegram events
  // ----------------
  sequence s_good;
    protocol_enable && stat_event == 8'h01;
  endsequence
  sequence s_errored;
    stat_event[7:1] != 7'h00;
  endsequence
  a_accept_good: assert property (s_good |=> telegram_accept)
    else $error("no accept after good telegram");
  a_drop_errored: assert property (s_errored |=> !telegram_accept)
    else $error("accept after errored telegram");
  a_accept_cause: assert property (telegram_accept |-> $past(stat_event) == 8'h01)
    else $error("accept without good telegram");
  // ----------------
  // settings
  // ----------------
  a_proto_quiet: assert property (!protocol_enable [*2] |-> !link_fault)
    else $error("link fault with protocol off");
  a_fault_clear: assert property (telegram_accept |-> ##[0:1] !link_fault)
    else $error("link fault kept after accept");
  a_addr_frozen: assert property ($past(address_valid) |-> $stable(active_address))
    else $error("address changed after latch");
  a_baud_legal: assert property (baud_divisor inside {16'hcb73, 16'h65b9, 16'h32dc,
    16'h196e, 16'h0cb7, 16'h087a, 16'h065b, 16'h0535, 16'h043d, 16'h029a})
    else $error("divisor outside rate table");
  // reset must be visible, so this one is not disabled by it
  a_reset_dflt: assert property (disable iff (1'b0) !aresetn |=> parity_mode == 2'h2
    && process_data_words == 8'h02 && parameter_channel_words == 7'h7f)
    else $error("settings not at defaults after reset");
endmodule
bind sfb_slave_cfg sfb_slave_cfg_properties sfb_slave_cfg_properties_i (.*);

// ### tb/sfb_slave_cfg_tb_top.sv
// self-checking bench for the fieldbus slave configuration block
`timescale 1ns/10ps
`include "sfb_regs.vh"
module sfb_slave_cfg_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rx_char, reply_done, address_valid, protocol_enable;
  logic        telegram_accept, gap_timeout, tx_inhibit, link_fault, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, stat_event, process_data_words;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, parity_mode;
  logic [3:0]  s_axi_wstrb, wstb;
  logic [6:0]  addr_switch, parameter_channel_words;
  logic [15:0] baud_divisor;
  logic [4:0]  active_address;
  integer      n_fail = 0, check_count = 0, acc_n = 0, gto_n = 0, i;
  logic [15:0] bdt [10] = '{16'hcb73, 16'h65b9, 16'h32dc, 16'h196e, 16'h0cb7,
                            16'h087a, 16'h065b, 16'h0535, 16'h043d, 16'h029a};
  // {offset, reset value}
  logic [23:0] df [11] = '{24'h000008, 24'h040000, 24'h080002, 24'h0c007f, 24'h1003e8,
                           24'h140000, 24'h180000, 24'h1c0001, 24'h200002, 24'h240064,
                           24'h300000};
  // {offset, written, read back}: refused values keep the old setting
  logic [23:0] tv [15] = '{24'h000e0d, 24'h00030d, 24'h000808, 24'h041f00, 24'h041e1e,
                           24'h0c0303, 24'h0c0404, 24'h0c0000, 24'h0c0500, 24'h0c7f7f,
                           24'h200000, 24'h200101, 24'h200301, 24'h200202, 24'h08ffff};
  sfb_slave_cfg #(.MS_CYCLES(10)) sfb_slave_cfg_i (.*);
  sfb_rx_model sfb_rx_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (telegram_accept === 1'b1) acc_n <= acc_n + 1;
  always @(posedge aclk) if (gap_timeout === 1'b1) gto_n <= gto_n + 1;
  // ----------------
  // tasks
  // ----------------
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task do_reset;
    begin
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(negedge aclk);
    end
  endtask
  // readies are sampled mid-cycle, where they already show the coming edge
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    logic pa, pw, ta, tw;
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= wstb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
        @(negedge aclk);
        ta = pa && s_axi_awready;
        tw = pw && s_axi_wready;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        pa = pa && !ta;
        pw = pw && !tw;
      end
      @(negedge aclk);
      while (s_axi_bvalid !== 1'b1) @(negedge aclk);
      chk("bresp", er, s_axi_bresp);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      repeat (2) @(negedge aclk);
    end
  endtask
  task rc(input [7:0] a, input [31:0] e, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      @(negedge aclk);
      while (s_axi_arready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(negedge aclk);
      while (s_axi_rvalid !== 1'b1) @(negedge aclk);
      chk("rresp", er, s_axi_rresp);
      chk("rdata", e, s_axi_rdata);
      @(posedge aclk);
      s_axi_rready  <= 1'b0;
      @(negedge aclk);
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    finish_test;
  end
  // ----------------
  // tests
  // ----------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    wstb = 4'hf;
    addr_switch = 7'h00;
    aresetn = 1'b0;
    do_reset;
    for (i = 0; i < 11; i++) rc(df[i][23:16], df[i][15:0], 2'h0);
    for (i = 4; i < 14; i++) begin
      wr(`SFB_A_RATE, i, 2'h0);
      chk("baud", bdt[i-4], baud_divisor);
    end
    for (i = 0; i < 15; i++) begin
      wr(tv[i][23:16], tv[i][15:8], 2'h0);
      rc(tv[i][23:16], tv[i][7:0], 2'h0);
      if (tv[i][23:16] == 8'h00) chk("baud", bdt[tv[i][7:0]-4], baud_divisor);
      if (tv[i][23:16] == 8'h0c) chk("pkw", tv[i][6:0], parameter_channel_words);
      if (tv[i][23:16] == 8'h20) chk("parity", tv[i][1:0], parity_mode);
      if (tv[i][23:16] == 8'h08) chk("pzd", tv[i][7:0], process_data_words);
    end
    // a partial word leaves the setting alone
    wstb = 4'h7;
    wr(`SFB_A_PAR, 32'h0, 2'h0);
    rc(`SFB_A_PAR, 32'h2, 2'h0);
    wstb = 4'hf;
    chk("address", 5'h00, active_address);
    wr(8'h60, 32'h0, 2'h2);
    rc(8'h60, 32'h0, 2'h2);
    @(posedge aclk);
    addr_switch <= 7'h09;
    do_reset;
    chk("address", 5'h09, active_address);
    rc(`SFB_A_STAT, 32'h29, 2'h0);
    @(posedge aclk);
    addr_switch <= 7'h00;
    aresetn     <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // software address lands before the latch at the fourth edge
    wr(`SFB_A_ADDR, 32'h0b, 2'h0);
    chk("address", 5'h0b, active_address);
    for (i = 0; i < 8; i++) begin
      sfb_rx_model_i.send(8'h01 << i);
      rc(8'(`SFB_A_CNT0 + 4 * i), 32'h1, 2'h0);
    end
    chk("accepts", 1, acc_n);
    sfb_rx_model_i.send(8'h05);
    rc(`SFB_A_CNT0, 32'h2, 2'h0);
    chk("accepts", 1, acc_n);
    wr(`SFB_A_PROT, 32'h0, 2'h0);
    sfb_rx_model_i.send(8'h01);
    rc(`SFB_A_PROT, 32'h0, 2'h0);
    chk("accepts", 1, acc_n);
    chk("protocol", 1'b0, protocol_enable);
    wr(`SFB_A_PROT, 32'h1, 2'h0);
    chk("protocol", 1'b1, protocol_enable);
    wr(`SFB_A_MASK, 32'hf, 2'h0);
    wr(`SFB_A_IRQ, 32'hf, 2'h0);
    wr(`SFB_A_MON, 32'h3, 2'h0);
    repeat (40) @(negedge aclk);
    chk("fault", 1'b1, link_fault);
    chk("irq", 1'b1, irq);
    rc(`SFB_A_STAT, 32'h6b, 2'h0);
    wr(`SFB_A_MASK, 32'h0, 2'h0);
    chk("irq", 1'b0, irq);
    sfb_rx_model_i.send(8'h01);
    repeat (2) @(negedge aclk);
    chk("fault", 1'b0, link_fault);
    wr(`SFB_A_MON, 32'h0, 2'h0);
    repeat (40) @(negedge aclk);
    chk("fault", 1'b0, link_fault);
    wr(`SFB_A_IRQ, 32'hf, 2'h0);
    rc(`SFB_A_IRQ, 32'h0, 2'h0);
    wr(`SFB_A_DEAD, 32'h1, 2'h0);
    sfb_rx_model_i.send(8'h01);
    @(negedge aclk);
    chk("inhibit", 1'b1, tx_inhibit);
    wr(`SFB_A_DEAD, 32'h0, 2'h0);
    wr(`SFB_A_IRQ, 32'hf, 2'h0);
    wr(`SFB_A_PROC, 32'h2, 2'h0);
    sfb_rx_model_i.send(8'h01);
    sfb_rx_model_i.send(8'h00);
    repeat (40) @(negedge aclk);
    rc(`SFB_A_IRQ, 32'h6, 2'h0);
    chk("gap pulses", 1, gto_n);
    wr(`SFB_A_IRQ, 32'h6, 2'h0);
    sfb_rx_model_i.send(8'h01);
    sfb_rx_model_i.reply;
    repeat (40) @(negedge aclk);
    rc(`SFB_A_IRQ, 32'h0, 2'h0);
    finish_test;
  end
endmodule
